// ### core/dpsem_ctrl.sv
// Purpose: host-side controller that drives one port of a dual-port semaphore unit
// Assumes: the device is asynchronous; its data pins are sampled through dpsem_sync
// Notes: one command at a time; results appear with done
`timescale 1ns/1ns
// What this block does
// - write zero requests, write one releases
// - deassert select or enable between reads
// - acquire writes zero then reads back
// - after failure poll or write one
// - write one to all flags at startup; here only when the user issues the init command
// - array enable high while select low
module dpsem_ctrl #(
  parameter int ACCESS_CYCLES = dpsem_pkg::ACCESS_CYC,
  parameter int GAP_CYCLES = dpsem_pkg::GAP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire dpsem_pkg::dpsem_req_t req,
  output logic done,
  output logic granted,
  output logic flag_value,
  output logic bus_error,
  output logic array_enable_n,
  output logic semaphore_select_n,
  output logic output_enable_n,
  output logic read_write_n,
  output logic [dpsem_pkg::ADDR_W-1:0] addr,
  output logic [dpsem_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [dpsem_pkg::DATA_W-1:0] data_in
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {
    DPSEM_IDLE = 3'b000, // standby, both selects high
    DPSEM_WRITE = 3'b001, // write strobe active
    DPSEM_WGAP = 3'b010, // strobes inactive after write
    DPSEM_READ = 3'b011, // select and output enable active
    DPSEM_RGAP = 3'b100, // strobes inactive after read
    DPSEM_DONE = 3'b101 // result pulse
  } dpsem_state_t;

  dpsem_state_t state; // current phase
  dpsem_pkg::dpsem_cmd_t cmd; // command being run
  logic [dpsem_pkg::IDX_W-1:0] index; // flag being accessed
  logic [dpsem_pkg::CNT_W-1:0] cnt; // cycles spent in phase
  logic [dpsem_pkg::DATA_W-1:0] data_sync; // synchronised read data
  logic phase_end; // current phase has lasted long enough
  logic write_bit; // request value for the write phase
  dpsem_pkg::dpsem_pins_t pins; // registered pin image

  localparam logic [dpsem_pkg::CNT_W-1:0] ACC_LAST = dpsem_pkg::CNT_W'(ACCESS_CYCLES - 1);
  localparam logic [dpsem_pkg::CNT_W-1:0] GAP_LAST = dpsem_pkg::CNT_W'(GAP_CYCLES - 1);
  localparam logic [dpsem_pkg::IDX_W-1:0] IDX_LAST = dpsem_pkg::IDX_W'(dpsem_pkg::FLAG_COUNT - 1);

  // ----------------------------------------
  // data input synchroniser
  // ----------------------------------------
  dpsem_sync #(
    .WIDTH(dpsem_pkg::DATA_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(data_in),
    .sync_out(data_sync)
  );

  // acceptance only when idle
  assign req_ready = (state == DPSEM_IDLE);

  // phase length check
  always_comb begin
    if (state == DPSEM_WRITE || state == DPSEM_READ) begin
      phase_end = (cnt == ACC_LAST);
    end else begin
      phase_end = (cnt == GAP_LAST);
    end
  end

  // zero requests the token, one releases it
  // release also withdraws a failed request left standing in our latch
  assign write_bit = (cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE) ? 1'b0 : 1'b1;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // phase walk: write, gap, read, gap, done
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= DPSEM_IDLE;
    end else begin
      unique case (state)
        DPSEM_IDLE: begin
          if (req_valid) begin
            // poll skips the write; acquire always writes first
            state <= (req.cmd == dpsem_pkg::DPSEM_CMD_POLL) ? DPSEM_READ : DPSEM_WRITE;
          end
        end
        DPSEM_WRITE: begin
          if (phase_end) begin
            state <= DPSEM_WGAP;
          end
        end
        DPSEM_WGAP: begin
          if (phase_end) begin
            if (cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE) begin
              state <= DPSEM_READ;
            end else if (cmd == dpsem_pkg::DPSEM_CMD_INIT && index != IDX_LAST) begin
              state <= DPSEM_WRITE;
            end else begin
              state <= DPSEM_DONE;
            end
          end
        end
        DPSEM_READ: begin
          if (phase_end) begin
            state <= DPSEM_RGAP;
          end
        end
        DPSEM_RGAP: begin
          if (phase_end) begin
            state <= DPSEM_DONE;
          end
        end
        DPSEM_DONE: begin
          state <= DPSEM_IDLE;
        end
      endcase
    end
  end

  // phase counter restarts on every phase change
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (state == DPSEM_IDLE || state == DPSEM_DONE || phase_end) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // command and flag index capture
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cmd <= dpsem_pkg::DPSEM_CMD_POLL;
      index <= '0;
    end else if (state == DPSEM_IDLE && req_valid) begin
      cmd <= req.cmd;
      // init walks every flag from zero
      index <= (req.cmd == dpsem_pkg::DPSEM_CMD_INIT) ? '0 : req.index;
    end else if (state == DPSEM_WGAP && phase_end && cmd == dpsem_pkg::DPSEM_CMD_INIT) begin
      index <= index + 1'b1;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // registered pin image per phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pins.array_enable_n <= 1'b1;
      pins.semaphore_select_n <= 1'b1;
      pins.output_enable_n <= 1'b1;
      pins.read_write_n <= 1'b1;
      pins.addr <= '0;
      pins.data_out <= '0;
      pins.data_oe <= 1'b0;
    end else begin
      // array never enabled: flags live in their own space
      pins.array_enable_n <= 1'b1;
      // upper address bits held low, only the index matters
      pins.addr <= {{(dpsem_pkg::ADDR_W - dpsem_pkg::IDX_W){1'b0}}, index};
      // select low during write or read phases, high in gaps
      pins.semaphore_select_n <= !(state == DPSEM_WRITE || state == DPSEM_READ);
      pins.output_enable_n <= !(state == DPSEM_READ);
      pins.read_write_n <= !(state == DPSEM_WRITE);
      // request value on bit 0; other bits follow it
      pins.data_out <= {dpsem_pkg::DATA_W{write_bit}};
      pins.data_oe <= (state == DPSEM_WRITE);
    end
  end

  assign array_enable_n = pins.array_enable_n;
  assign semaphore_select_n = pins.semaphore_select_n;
  assign output_enable_n = pins.output_enable_n;
  assign read_write_n = pins.read_write_n;
  assign addr = pins.addr;
  assign data_out = pins.data_out;
  assign data_oe = pins.data_oe;

  // ----------------------------------------
  // result
  // ----------------------------------------
  // sample the frozen read value in the done phase: the synchroniser needs
  // about four edges after the device drives the bus, and its pipe still
  // holds what was captured while select and output enable were low
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_value <= 1'b1;
      granted <= 1'b0;
      bus_error <= 1'b0;
    end else if (state == DPSEM_DONE &&
                 (cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE || cmd == dpsem_pkg::DPSEM_CMD_POLL)) begin
      flag_value <= data_sync[0];
      // zero back means token held, one means failed
      granted <= (cmd == dpsem_pkg::DPSEM_CMD_ACQUIRE) && !data_sync[0];
      // all data bits should carry the same flag value
      bus_error <= !((&data_sync) || !(|data_sync));
    end else if (state == DPSEM_IDLE && req_valid) begin
      granted <= 1'b0;
      bus_error <= 1'b0;
    end
  end

  // completion pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      done <= 1'b0;
    end else begin
      done <= (state == DPSEM_DONE);
    end
  end
endmodule : dpsem_ctrl

// ### core/dpsem_pkg.sv
// Purpose: shared constants and types for the semaphore port controller
// Assumes: one controller drives one port of the dual-port device
// Notes: pin levels are active low where the name ends in _n
package dpsem_pkg;
  // ----------------------------------------
  // flag space
  // ----------------------------------------
  localparam int FLAG_COUNT = 8; // number of semaphore flags
  localparam int IDX_W = 3; // flag index width
  localparam int DATA_W = 8; // device data bus width
  localparam int ADDR_W = 15; // device address bus width
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4; // clk_sys period
  localparam int ACCESS_NS = 20; // least access time held per strobe
  localparam int GAP_NS = 8; // least inactive time between accesses
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4; // width of the phase counter
  // ----------------------------------------
  // commands
  // ----------------------------------------
  typedef enum logic [1:0] {
    DPSEM_CMD_ACQUIRE = 2'b00, // write zero then read back
    DPSEM_CMD_RELEASE = 2'b01, // write one
    DPSEM_CMD_POLL = 2'b10, // read only
    DPSEM_CMD_INIT = 2'b11 // write one to every flag
  } dpsem_cmd_t;
  // request from the user side
  typedef struct packed {
    dpsem_cmd_t cmd;
    logic [IDX_W-1:0] index;
  } dpsem_req_t;
  // device pins driven by the controller
  typedef struct packed {
    logic array_enable_n;
    logic semaphore_select_n;
    logic output_enable_n;
    logic read_write_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_out;
    logic data_oe;
  } dpsem_pins_t;
endpackage : dpsem_pkg

// ### core/dpsem_sync.sv
// Purpose: three-stage synchroniser for the device data bus
// Assumes: data arrives asynchronously from the device pins
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ns
module dpsem_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1; // first flop, read only by stage2
  logic [WIDTH-1:0] stage2; // second flop
  logic [WIDTH-1:0] stage3; // third flop
  // ----------------------------------------
  // per-bit capture and agreement filter
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      // shift chain and stable output
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          stage1[b] <= 1'b1;
          stage2[b] <= 1'b1;
          stage3[b] <= 1'b1;
          sync_out[b] <= 1'b1;
        end else begin
          stage1[b] <= async_in[b];
          stage2[b] <= stage1[b];
          stage3[b] <= stage2[b];
          if (stage2[b] == stage3[b]) begin
            sync_out[b] <= stage3[b];
          end
        end
      end
    end
  endgenerate
endmodule : dpsem_sync

// ### sim/dpsem_ctrl_chk.sv
// Purpose: pin protocol checks on the semaphore port controller
// Assumes: default access length of five cycles
// Notes: bound into every dpsem_ctrl instance
`timescale 1ns/1ns
module dpsem_ctrl_chk #(
  parameter int ACCESS_CYCLES = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire logic done,
  input wire logic array_enable_n,
  input wire logic semaphore_select_n,
  input wire logic output_enable_n,
  input wire logic read_write_n,
  input wire logic [dpsem_pkg::ADDR_W-1:0] addr,
  input wire logic [dpsem_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_array_held: assert property (array_enable_n)
    else $error("array enable went low");
  chk_write_value: assert property (!read_write_n |->
    data_oe && !semaphore_select_n && data_out == {8{data_out[0]}})
    else $error("write pins wrong");
  chk_write_len: assert property ($fell(read_write_n) |->
    !read_write_n [*5] ##1 read_write_n)
    else $error("write strobe length wrong");
  chk_read_len: assert property ($fell(output_enable_n) |->
    !output_enable_n [*5] ##1 output_enable_n)
    else $error("read strobe length wrong");
  chk_read_pins: assert property (!output_enable_n |->
    !semaphore_select_n && read_write_n && !data_oe)
    else $error("read pins wrong");
  chk_select_gap: assert property ($rose(semaphore_select_n) |=> semaphore_select_n)
    else $error("select gap too short");
  chk_upper_addr: assert property (!semaphore_select_n |-> addr[14:3] == 12'h000)
    else $error("upper address not zero");
  chk_done_ready: assert property (done |=> req_ready && !done)
    else $error("done not a pulse");
endmodule : dpsem_ctrl_chk
bind dpsem_ctrl dpsem_ctrl_chk #(.ACCESS_CYCLES(ACCESS_CYCLES)) chk (.clk_sys, .rst_n,
  .req_ready, .done, .array_enable_n, .semaphore_select_n, .output_enable_n,
  .read_write_n, .addr, .data_out, .data_oe);

// ### sim/dpsem_dev.sv
// Purpose: model of the far device's eight semaphore flags
// Assumes: sampled on the bench clock; port b driven by the bench
// Notes: latches start at zero, so both sides must free every flag
`timescale 1ns/1ns
module dpsem_dev (
  input wire logic clk_sys,
  input wire logic a_sel_n,
  input wire logic a_oe_n,
  input wire logic a_rw_n,
  input wire logic [dpsem_pkg::ADDR_W-1:0] a_addr,
  input wire logic [dpsem_pkg::DATA_W-1:0] a_dout,
  output logic [dpsem_pkg::DATA_W-1:0] a_din,
  input wire logic b_sel_n,
  input wire logic b_rw_n,
  input wire logic [2:0] b_idx,
  input wire logic b_d0,
  output logic b_flag
);
  logic [7:0] la = 8'h00;
  logic [7:0] lb = 8'h00;
  logic [7:0] own_a = 8'h00;
  logic [7:0] own_b = 8'h00;
  logic a_rd = 1'b0;
  logic a_hold = 1'b1;
  // request latches change only while select and write strobe are low
  always @(posedge clk_sys) begin
    if (!a_sel_n && !a_rw_n) la[a_addr[2:0]] <= a_dout[0];
    if (!b_sel_n && !b_rw_n) lb[b_idx] <= b_d0;
  end
  // first zero wins; a release hands over to a pending request
  always @(posedge clk_sys) begin
    for (int k = 0; k < 8; k++) begin
      if (!own_a[k] && !own_b[k]) begin
        own_a[k] <= !la[k];
        own_b[k] <= la[k] && !lb[k];
      end else if (own_a[k] && la[k]) begin
        own_a[k] <= 1'b0;
        own_b[k] <= !lb[k];
      end else if (own_b[k] && lb[k]) begin
        own_b[k] <= 1'b0;
        own_a[k] <= !la[k];
      end
    end
  end
  // read value frozen while select and output enable stay low
  always @(posedge clk_sys) begin
    a_rd <= !a_sel_n && !a_oe_n;
    if (!a_sel_n && !a_oe_n && !a_rd) a_hold <= !own_a[a_addr[2:0]];
  end
  // flag on all bits; a released bus shows the inverse
  assign a_din = a_rd ? {8{a_hold}} : {8{!a_hold}};
  assign b_flag = !own_b[b_idx];
endmodule : dpsem_dev

// ### sim/tb_top.sv
// Purpose: self-checking bench for the semaphore port controller
// Assumes: default access and gap lengths
// Notes: the bench plays the device's other port
`timescale 1ns/1ns
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  dpsem_pkg::dpsem_req_t req = '0;
  logic req_ready, done, granted, flag_value, bus_error, data_oe, b_flag;
  logic array_enable_n, semaphore_select_n, output_enable_n, read_write_n;
  logic [dpsem_pkg::ADDR_W-1:0] addr;
  logic [dpsem_pkg::DATA_W-1:0] data_out, data_in;
  logic b_sel_n = 1'b1;
  logic b_rw_n = 1'b1;
  logic b_d0 = 1'b1;
  logic [2:0] b_idx = 3'h0;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  dpsem_ctrl uut (.clk_sys, .rst_n, .req_valid, .req_ready, .req, .done, .granted,
    .flag_value, .bus_error, .array_enable_n, .semaphore_select_n, .output_enable_n,
    .read_write_n, .addr, .data_out, .data_oe, .data_in);
  dpsem_dev dev (.clk_sys, .a_sel_n(semaphore_select_n), .a_oe_n(output_enable_n),
    .a_rw_n(read_write_n), .a_addr(addr), .a_dout(data_out), .a_din(data_in),
    .b_sel_n, .b_rw_n, .b_idx, .b_d0, .b_flag);
  task automatic check(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %b want %b", $time, got, exp);
    end
  endtask : check
  // one command, waiting a bounded time for done
  task automatic run(input dpsem_pkg::dpsem_cmd_t c, input logic [2:0] i);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{cmd: c, index: i};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(done, 1'b1);
  endtask : run
  // other port writes one flag
  task automatic b_write(input logic [2:0] i, input logic v);
    @(posedge clk_sys);
    b_idx <= i;
    b_d0 <= v;
    b_sel_n <= 1'b0;
    b_rw_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    b_sel_n <= 1'b1;
    b_rw_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : b_write
  // both sides free all flags at startup
  task automatic t_init;
    for (int i = 0; i < 8; i++) b_write(3'(i), 1'b1);
    run(dpsem_pkg::DPSEM_CMD_INIT, 3'h0);
    check((dev.own_a | dev.own_b) == 8'h00, 1'b1);
    run(dpsem_pkg::DPSEM_CMD_POLL, 3'h0);
    check(flag_value, 1'b1);
  endtask : t_init
  // free flag taken by write then read back
  task automatic t_take;
    run(dpsem_pkg::DPSEM_CMD_ACQUIRE, 3'h5);
    check(granted, 1'b1);
    check(flag_value, 1'b0);
    check(bus_error, 1'b0);
  endtask : t_take
  // pending request, hand-over, failed request and withdrawal
  task automatic t_pass;
    b_write(3'h5, 1'b0);
    run(dpsem_pkg::DPSEM_CMD_POLL, 3'h5);
    check(flag_value, 1'b0);
    run(dpsem_pkg::DPSEM_CMD_RELEASE, 3'h5);
    check(b_flag, 1'b0);
    run(dpsem_pkg::DPSEM_CMD_ACQUIRE, 3'h5);
    check(granted, 1'b0);
    check(flag_value, 1'b1);
    run(dpsem_pkg::DPSEM_CMD_RELEASE, 3'h5);
    b_write(3'h5, 1'b1);
    run(dpsem_pkg::DPSEM_CMD_POLL, 3'h5);
    check(flag_value, 1'b1);
    check(b_flag, 1'b1);
  endtask : t_pass
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch at %0t: cycle limit reached", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_init();
    t_take();
    t_pass();
    tally_and_finish();
  end
endmodule : tb_top
